// [cvspc_consts.svh]
// Constants for the converter control and status block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
//
// What this block does
// - PCM-in DMA enable raises PCM input refill requests; clear gives none; resets zero.
// - Two-bit CVSD format: mu-law, A-law, linear, reserved; resets zero.
// - Companding law bit picks mu-law at 0, A-law at 1.
// - Two-bit resolution shifts linear PCM right 0 to 3 bits, sign extended.
// - Log PCM is expanded left-justified to 13 or 14 bits, then attenuated too.
// - Status is 16-bit read-only, cleared at reset and while module disabled.
// - Nearly-full sets when only three empty locations remain in out FIFO.
// - Nearly-full drives FIFO interrupt and out-FIFO DMA request when enabled.
// - Status read clears nearly-full and nearly-empty even during freeze, unless one sets in the same cycle.
// - PCM service sets on PCM out full or PCM in empty; read clears unless frozen.
// - Underflow sets on converter read of empty in FIFO; error interrupt; read clears unless frozen.
// - Overflow sets on converter write of full out FIFO; error interrupt; read clears unless frozen.
// - In-FIFO level reports seven minus the word count: 111b when empty, 000b at 7 or 8 words.
// - Out-FIFO level reports valid words: 000b when empty, 111b at 7 or 8 words.
// - Nearly-empty sets at three words left; FIFO interrupt and in-FIFO DMA request.
// - Freeze stops in-FIFO drain, out-FIFO fill and PCM output updates.
// - Each CVSD FIFO holds eight 16-bit words.
`ifndef CVSPC_CONSTS_SVH
`define CVSPC_CONSTS_SVH
`define CVSPC_OFS_CVSD_IN 6'h20
`define CVSPC_OFS_CVSD_OUT 6'h22
`define CVSPC_OFS_PCM_IN 6'h24
`define CVSPC_OFS_PCM_OUT 6'h26
`define CVSPC_OFS_CTRL 6'h30
`define CVSPC_OFS_STAT 6'h32
`define CVSPC_CTRL_RESET 16'h0000
`define CVSPC_CTRL_MASK 16'hF9FF
`define CVSPC_CTL_EN 0
`define CVSPC_CTL_CLKEN 1
`define CVSPC_CTL_ERRIE 2
`define CVSPC_CTL_FIFOIE 3
`define CVSPC_CTL_PCMIE 4
`define CVSPC_CTL_CVSD_IN_DMA 5
`define CVSPC_CTL_CVSD_OUT_DMA 6
`define CVSPC_CTL_PCM_OUT_DMA 7
`define CVSPC_CTL_PCM_IN_DMA 8
`define CVSPC_CTL_FMT 12:11
`define CVSPC_CTL_LAW 13
`define CVSPC_CTL_RES 15:14
`define CVSPC_ST_NE 0
`define CVSPC_ST_NF 1
`define CVSPC_ST_PCM 2
`define CVSPC_ST_UDF 3
`define CVSPC_ST_OVF 4
`define CVSPC_ST_INL 7:5
`define CVSPC_ST_OUTL 10:8
`define CVSPC_ST_RSVD 15:11
`define CVSPC_FIFO_DEPTH 8
`define CVSPC_NEAR_GAP 3
`define CVSPC_LVL_SAT 7
`define CVSPC_MU_BIAS 16'h0021
`define CVSPC_A_XOR 8'h55
`endif

// [cvspc_pkg.sv]
// Types shared by the converter control and status block.
// Assumes cvspc_consts.svh is reachable by bare name.
`include "cvspc_consts.svh"
package cvspc_pkg;
  typedef logic [15:0] cvspc_word_t;
  // Order follows the two-bit field encoding 00, 01, 10, 11
  typedef enum logic [1:0] {CVSPC_FMT_MULAW, CVSPC_FMT_ALAW, CVSPC_FMT_LINEAR, CVSPC_FMT_RSVD} cvspc_fmt_e;
endpackage

// [cvspc_fifo.sv]
// Flip-flop FIFO for CVSD words, used for the input and output streams.
// Assumes push and pop are already qualified by the parent; overflow and underflow are ignored here.
`include "cvspc_consts.svh"
module cvspc_fifo import cvspc_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `CVSPC_FIFO_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1),
  parameter int PTR_W = $clog2(DEPTH)
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic [CNT_W-1:0] o_count,
  output logic o_full,
  output logic o_empty
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic do_push, do_pop;

  assign o_full = (o_count == CNT_W'(DEPTH));
  assign o_empty = (o_count == '0);
  assign do_push = i_push && !o_full;
  assign do_pop = i_pop && !o_empty;
  assign o_head = mem_q[rd_ptr_q];

  // Storage has no reset: contents are never visible before the first push
  always_ff @(posedge i_core_clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      o_count <= '0;
    end else if (i_flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      o_count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      o_count <= o_count + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end
endmodule

// [cvspc_atten.sv]
// Expands log PCM and attenuates PCM words headed for the CVSD encoder.
// Assumes log samples sit in bits 7:0 of the input word; purely combinational.
`include "cvspc_consts.svh"
module cvspc_atten import cvspc_pkg::*; (
  input wire logic [15:0] i_pcm,
  input wire logic [1:0] i_fmt,
  input wire logic [1:0] i_res,
  output logic [15:0] o_pcm
);
  // Mu-law to left-justified 14-bit linear, two low bits zero
  function automatic logic [15:0] mu_expand(input logic [7:0] b);
    logic [7:0] u;
    logic [15:0] mag;
    u = ~b;
    mag = ((16'({u[3:0], 1'b0}) + `CVSPC_MU_BIAS) << u[6:4]) - `CVSPC_MU_BIAS;
    mu_expand = (u[7] ? (16'h0000 - mag) : mag) << 2;
  endfunction

  // A-law to left-justified 13-bit linear, three low bits zero
  function automatic logic [15:0] a_expand(input logic [7:0] b);
    logic [7:0] a;
    logic [15:0] mag;
    a = b ^ `CVSPC_A_XOR;
    mag = (a[6:4] == 3'h0) ? 16'({a[3:0], 1'b1}) : (16'({1'b1, a[3:0], 1'b1}) << (a[6:4] - 3'h1));
    a_expand = (a[7] ? mag : (16'h0000 - mag)) << 3;
  endfunction

  logic [15:0] lin;
  always_comb begin
    case (cvspc_fmt_e'(i_fmt))
      CVSPC_FMT_MULAW: lin = mu_expand(i_pcm[7:0]);
      CVSPC_FMT_ALAW: lin = a_expand(i_pcm[7:0]);
      default: lin = i_pcm;
    endcase
  end

  // Shift applies after expansion so log and linear inputs scale alike
  assign o_pcm = 16'($signed(lin) >>> i_res);
endmodule

// [cvspc_top.sv]
// Control and status for the CVSD/PCM converter: control and status registers, CVSD FIFOs,
// PCM data registers, service flags, interrupt and DMA request levels.
// Assumes a single-cycle peripheral bus with one-hot read/write strobes and an external converter core.
`include "cvspc_consts.svh"
module cvspc_top import cvspc_pkg::*; #(
  parameter int FIFO_DEPTH = `CVSPC_FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [5:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  input wire logic i_freeze,
  input wire logic i_conv_in_pop,
  output logic [15:0] o_conv_in_data,
  input wire logic i_conv_out_push,
  input wire logic [15:0] i_conv_out_data,
  input wire logic i_conv_pcm_out_wr,
  input wire logic [15:0] i_conv_pcm_out_data,
  input wire logic i_conv_pcm_in_rd,
  output logic [15:0] o_conv_pcm_in_data,
  output logic o_conv_clk_en,
  output logic [1:0] o_cvsd_format_sel,
  output logic o_companding_law_sel,
  output logic o_fifo_irq,
  output logic o_err_irq,
  output logic o_pcm_irq,
  output logic o_dma_req_cvsd_in,
  output logic o_dma_req_cvsd_out,
  output logic o_dma_req_pcm_in,
  output logic o_dma_req_pcm_out
);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] NF_TH = CNT_W'(FIFO_DEPTH - `CVSPC_NEAR_GAP);
  localparam logic [CNT_W-1:0] NE_TH = CNT_W'(`CVSPC_NEAR_GAP);

  // Saturating level fields: counts of 7 and 8 share one code
  function automatic logic [2:0] out_level(input logic [CNT_W-1:0] cnt);
    out_level = (cnt >= CNT_W'(`CVSPC_LVL_SAT)) ? 3'(`CVSPC_LVL_SAT) : 3'(cnt);
  endfunction

  function automatic logic [2:0] in_level(input logic [CNT_W-1:0] cnt);
    in_level = (cnt >= CNT_W'(`CVSPC_LVL_SAT)) ? 3'h0 : 3'(CNT_W'(`CVSPC_LVL_SAT) - cnt);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus decode and control register

  cvspc_word_t converter_control_q;
  logic module_enable;
  logic wr_ctrl, wr_cvsd_in, wr_pcm_in, rd_cvsd_out, rd_pcm_out, rd_stat;

  assign module_enable = converter_control_q[`CVSPC_CTL_EN];
  assign wr_ctrl = i_wr && (i_addr == `CVSPC_OFS_CTRL);
  // Data registers are reachable only while the module is enabled
  assign wr_cvsd_in = i_wr && module_enable && (i_addr == `CVSPC_OFS_CVSD_IN);
  assign wr_pcm_in = i_wr && module_enable && (i_addr == `CVSPC_OFS_PCM_IN);
  assign rd_cvsd_out = i_rd && module_enable && (i_addr == `CVSPC_OFS_CVSD_OUT);
  assign rd_pcm_out = i_rd && module_enable && (i_addr == `CVSPC_OFS_PCM_OUT);
  assign rd_stat = i_rd && (i_addr == `CVSPC_OFS_STAT);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      converter_control_q <= `CVSPC_CTRL_RESET;
    end else if (wr_ctrl) begin
      converter_control_q <= i_wdata & `CVSPC_CTRL_MASK;
    end
  end

  assign o_conv_clk_en = converter_control_q[`CVSPC_CTL_CLKEN];
  assign o_cvsd_format_sel = converter_control_q[`CVSPC_CTL_FMT];
  assign o_companding_law_sel = converter_control_q[`CVSPC_CTL_LAW];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // CVSD FIFOs

  logic [CNT_W-1:0] in_cnt, out_cnt, in_cnt_prev_q, out_cnt_prev_q;
  logic in_full, in_empty, out_full, out_empty;
  logic in_pop_acc, out_push_acc;
  cvspc_word_t in_head, out_head;

  // Freeze stalls the converter side only; the bus still moves data
  assign in_pop_acc = i_conv_in_pop && module_enable && !i_freeze;
  assign out_push_acc = i_conv_out_push && module_enable && !i_freeze;

  cvspc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_in_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_flush(!module_enable),
    .i_push(wr_cvsd_in),
    .i_data(i_wdata),
    .i_pop(in_pop_acc),
    .o_head(in_head),
    .o_count(in_cnt),
    .o_full(in_full),
    .o_empty(in_empty)
  );

  cvspc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_out_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_flush(!module_enable),
    .i_push(out_push_acc),
    .i_data(i_conv_out_data),
    .i_pop(rd_cvsd_out),
    .o_head(out_head),
    .o_count(out_cnt),
    .o_full(out_full),
    .o_empty(out_empty)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv_in_data <= 16'h0000;
    end else if (in_pop_acc && !in_empty) begin
      o_conv_in_data <= in_head;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_cnt_prev_q <= '0;
      out_cnt_prev_q <= '0;
    end else begin
      in_cnt_prev_q <= in_cnt;
      out_cnt_prev_q <= out_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // PCM data registers

  cvspc_word_t pcm_input_reg_q, pcm_output_reg_q, pcm_atten;
  logic pcm_in_empty_q, pcm_out_full_q, pcm_out_upd;

  assign pcm_out_upd = i_conv_pcm_out_wr && module_enable && !i_freeze;

  cvspc_atten u_atten (
    .i_pcm(pcm_input_reg_q),
    .i_fmt(converter_control_q[`CVSPC_CTL_FMT]),
    .i_res(converter_control_q[`CVSPC_CTL_RES]),
    .o_pcm(pcm_atten)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pcm_input_reg_q <= 16'h0000;
      o_conv_pcm_in_data <= 16'h0000;
    end else begin
      if (wr_pcm_in) begin
        pcm_input_reg_q <= i_wdata;
      end
      if (i_conv_pcm_in_rd) begin
        o_conv_pcm_in_data <= pcm_atten;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pcm_in_empty_q <= 1'b0;
    end else if (!module_enable) begin
      pcm_in_empty_q <= 1'b0;
    end else if (i_conv_pcm_in_rd) begin
      pcm_in_empty_q <= 1'b1;
    end else if (wr_pcm_in) begin
      pcm_in_empty_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pcm_output_reg_q <= 16'h0000;
      pcm_out_full_q <= 1'b0;
    end else if (!module_enable) begin
      pcm_out_full_q <= 1'b0;
    end else if (pcm_out_upd) begin
      pcm_output_reg_q <= i_conv_pcm_out_data;
      pcm_out_full_q <= 1'b1;
    end else if (rd_pcm_out) begin
      pcm_out_full_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Status flags: hardware set wins over a clearing read in the same cycle

  logic nf_q, ne_q, pcm_q, udf_q, ovf_q;
  logic nf_set, ne_set, pcm_set, udf_set, ovf_set, sticky_clr, flag_clr;
  cvspc_word_t status_word;

  // Clearing on the disabling write itself keeps flags, interrupts and CVSD DMA requests from outliving the enable
  assign flag_clr = !module_enable || (wr_ctrl && !i_wdata[`CVSPC_CTL_EN]);

  assign nf_set = (out_cnt == NF_TH) && (out_cnt_prev_q != NF_TH);
  assign ne_set = (in_cnt == NE_TH) && (in_cnt_prev_q != NE_TH);
  assign pcm_set = pcm_out_upd || i_conv_pcm_in_rd;
  assign udf_set = in_pop_acc && in_empty;
  assign ovf_set = out_push_acc && out_full;
  assign sticky_clr = rd_stat && !i_freeze;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nf_q <= 1'b0;
      ne_q <= 1'b0;
    end else if (flag_clr) begin
      nf_q <= 1'b0;
      ne_q <= 1'b0;
    end else begin
      nf_q <= nf_set || (nf_q && !rd_stat);
      ne_q <= ne_set || (ne_q && !rd_stat);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pcm_q <= 1'b0;
      udf_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (flag_clr) begin
      pcm_q <= 1'b0;
      udf_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      pcm_q <= pcm_set || (pcm_q && !sticky_clr);
      udf_q <= udf_set || (udf_q && !sticky_clr);
      ovf_q <= ovf_set || (ovf_q && !sticky_clr);
    end
  end

  always_comb begin
    status_word = 16'h0000;
    if (module_enable) begin
      status_word[`CVSPC_ST_NE] = ne_q;
      status_word[`CVSPC_ST_NF] = nf_q;
      status_word[`CVSPC_ST_PCM] = pcm_q;
      status_word[`CVSPC_ST_UDF] = udf_q;
      status_word[`CVSPC_ST_OVF] = ovf_q;
      status_word[`CVSPC_ST_INL] = in_level(in_cnt);
      status_word[`CVSPC_ST_OUTL] = out_level(out_cnt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read data: captured at the strobe edge, so a status read returns the pre-clear value

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `CVSPC_OFS_CTRL: o_rdata <= converter_control_q;
        `CVSPC_OFS_STAT: o_rdata <= status_word;
        `CVSPC_OFS_CVSD_OUT: o_rdata <= (module_enable && !out_empty) ? out_head : 16'h0000;
        `CVSPC_OFS_PCM_OUT: o_rdata <= module_enable ? pcm_output_reg_q : 16'h0000;
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Interrupt and DMA request levels

  assign o_fifo_irq = converter_control_q[`CVSPC_CTL_FIFOIE] && (nf_q || ne_q);
  assign o_err_irq = converter_control_q[`CVSPC_CTL_ERRIE] && (udf_q || ovf_q);
  assign o_pcm_irq = converter_control_q[`CVSPC_CTL_PCMIE] && pcm_q;
  assign o_dma_req_cvsd_out = converter_control_q[`CVSPC_CTL_CVSD_OUT_DMA] && nf_q;
  assign o_dma_req_cvsd_in = converter_control_q[`CVSPC_CTL_CVSD_IN_DMA] && ne_q;
  assign o_dma_req_pcm_in = converter_control_q[`CVSPC_CTL_PCM_IN_DMA] && pcm_in_empty_q;
  assign o_dma_req_pcm_out = converter_control_q[`CVSPC_CTL_PCM_OUT_DMA] && pcm_out_full_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_stat_read;
    rd_stat && module_enable && !wr_ctrl;
  endsequence

  sequence s_conv_take_pcm;
    i_conv_pcm_in_rd && module_enable && !wr_ctrl && !wr_pcm_in;
  endsequence

  chk_pcm_dma_gate: assert property (
    s_conv_take_pcm ##1 (!wr_pcm_in && !wr_ctrl) |->
      (o_dma_req_pcm_in == converter_control_q[`CVSPC_CTL_PCM_IN_DMA]))
    else $error("PCM input DMA request does not follow its enable");

  chk_stat_disabled: assert property (
    !module_enable |-> (status_word == 16'h0000) && !o_fifo_irq && !o_err_irq)
    else $error("Status not clear while module disabled");

  chk_nf_set: assert property (
    module_enable && !wr_ctrl && (out_cnt == NF_TH) && (out_cnt_prev_q != NF_TH) |=> nf_q)
    else $error("Nearly-full missed at three free locations");

  chk_nf_requests: assert property (
    nf_q |-> (o_fifo_irq == converter_control_q[`CVSPC_CTL_FIFOIE]) &&
      (o_dma_req_cvsd_out == converter_control_q[`CVSPC_CTL_CVSD_OUT_DMA]))
    else $error("Nearly-full does not drive interrupt or DMA request");

  chk_read_clear_near: assert property (
    s_stat_read ##0 (!nf_set && !ne_set) |=> !nf_q && !ne_q)
    else $error("Status read did not clear near flags");

  chk_pcm_freeze_hold: assert property (
    s_stat_read ##0 (i_freeze && pcm_q) |=> pcm_q [*1] ##0 status_word[`CVSPC_ST_PCM])
    else $error("PCM service flag cleared during freeze");

  chk_pcm_read_clear: assert property (
    s_stat_read ##0 (!i_freeze && !pcm_set) |=> !pcm_q)
    else $error("PCM service flag not cleared by read");

  chk_udf_raise: assert property (
    module_enable && !wr_ctrl && i_conv_in_pop && !i_freeze && in_empty |=> udf_q
      ##0 (o_err_irq == converter_control_q[`CVSPC_CTL_ERRIE]))
    else $error("Underflow not flagged");

  chk_ovf_raise: assert property (
    module_enable && !wr_ctrl && i_conv_out_push && !i_freeze && out_full |=> ovf_q
      ##0 (o_err_irq == converter_control_q[`CVSPC_CTL_ERRIE]))
    else $error("Overflow not flagged");

  chk_in_level: assert property (
    module_enable && in_empty |-> status_word[`CVSPC_ST_INL] == 3'h7)
    else $error("Input level wrong when empty");

  chk_out_level: assert property (
    module_enable && (out_cnt >= CNT_W'(`CVSPC_LVL_SAT)) |-> status_word[`CVSPC_ST_OUTL] == 3'h7)
    else $error("Output level wrong near full");

  chk_ne_set: assert property (
    module_enable && !wr_ctrl && (in_cnt == NE_TH) && (in_cnt_prev_q != NE_TH) |=> ne_q
      ##0 (o_dma_req_cvsd_in == converter_control_q[`CVSPC_CTL_CVSD_IN_DMA]))
    else $error("Nearly-empty missed at three words");

  chk_freeze_stall: assert property (
    i_freeze && !wr_cvsd_in && !rd_cvsd_out && !wr_ctrl && module_enable |=>
      $stable(in_cnt) && $stable(out_cnt) && $stable(pcm_output_reg_q))
    else $error("Converter moved data during freeze");

  chk_fifo_bound: assert property (
    (in_cnt <= CNT_W'(FIFO_DEPTH)) && (out_cnt <= CNT_W'(FIFO_DEPTH)))
    else $error("FIFO count beyond depth");

  chk_stat_rsvd: assert property (
    i_rd && (i_addr == `CVSPC_OFS_STAT) |=> o_rdata[`CVSPC_ST_RSVD] == 5'h00)
    else $error("Reserved status bits not zero");
endmodule

// [cvspc_host.sv]
// Peripheral bus master standing in for the CPU and DMA controller.
// Assumes single-cycle strobes sampled on the rising edge, read data valid one cycle later.
module cvspc_host (
  input wire logic i_core_clk,
  input wire logic [15:0] i_rdata,
  output logic [5:0] o_addr = 6'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [15:0] o_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so a stale value never passes
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_core_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_core_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
  // Word count comes from the fill field, never from the nearly-full flag
  task automatic lvl(output logic [15:0] n);
    logic [15:0] s;
    rd(6'h32, s);
    n = {13'h0000, s[10:8]};
  endtask
endmodule

// [cvspc_top_bench.sv]
// Self-checking bench for the converter control and status block.
// Assumes the bus model cvspc_host and a converter core played by the bench.
module cvspc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [5:0] i_addr;
  logic i_wr, i_rd;
  logic [15:0] i_wdata, o_rdata, o_conv_in_data, o_conv_pcm_in_data;
  logic [15:0] i_conv_out_data = 16'h0000, i_conv_pcm_out_data = 16'h0000;
  logic i_freeze = 1'b0, i_conv_in_pop = 1'b0, i_conv_out_push = 1'b0;
  logic i_conv_pcm_out_wr = 1'b0, i_conv_pcm_in_rd = 1'b0;
  logic o_conv_clk_en, o_companding_law_sel, o_fifo_irq, o_err_irq, o_pcm_irq;
  logic [1:0] o_cvsd_format_sel;
  logic o_dma_req_cvsd_in, o_dma_req_cvsd_out, o_dma_req_pcm_in, o_dma_req_pcm_out;
  logic [15:0] v;
  int bad_count = 0;
  int checks_done = 0;
  always #20 i_core_clk = ~i_core_clk;
  cvspc_top dut (.i_core_clk, .i_resetn, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_freeze,
    .i_conv_in_pop, .o_conv_in_data, .i_conv_out_push, .i_conv_out_data, .i_conv_pcm_out_wr,
    .i_conv_pcm_out_data, .i_conv_pcm_in_rd, .o_conv_pcm_in_data, .o_conv_clk_en, .o_cvsd_format_sel,
    .o_companding_law_sel, .o_fifo_irq, .o_err_irq, .o_pcm_irq, .o_dma_req_cvsd_in,
    .o_dma_req_cvsd_out, .o_dma_req_pcm_in, .o_dma_req_pcm_out);
  cvspc_host host (.i_core_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
    .o_wdata(i_wdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdchk(input string n, input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.rd(a, d);
    chk(n, e, d);
  endtask
  // Converter pulse 0 pop, 1 push, 2 PCM out update, 3 PCM in take; one settle cycle after
  task automatic conv(input int k, input logic [15:0] d);
    @(negedge i_core_clk);
    i_conv_in_pop = (k == 0);
    i_conv_out_push = (k == 1);
    i_conv_pcm_out_wr = (k == 2);
    i_conv_pcm_in_rd = (k == 3);
    i_conv_out_data = d;
    i_conv_pcm_out_data = d;
    @(negedge i_core_clk);
    {i_conv_in_pop, i_conv_out_push, i_conv_pcm_out_wr, i_conv_pcm_in_rd} = 4'h0;
    i_conv_out_data = ~d;
    i_conv_pcm_out_data = ~d;
    @(negedge i_core_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk("ctrl", 6'h30, 16'h0000);
    rdchk("stat", 6'h32, 16'h0000);
    host.wr(6'h30, 16'hFFFF);
    rdchk("ctrl", 6'h30, 16'hF9FF);
    chk("clk_en", 16'h0001, {15'h0000, o_conv_clk_en});
    for (int f = 0; f < 4; f++) begin
      host.wr(6'h30, {2'b00, 1'(f), 2'(f), 11'h001});
      chk("fmt", 16'(f), {14'h0000, o_cvsd_format_sel});
      chk("law", 16'(f % 2), {15'h0000, o_companding_law_sel});
    end
    $display("test regs done");
  endtask
  task automatic t_in;
    host.wr(6'h30, 16'h002D);
    rdchk("stat", 6'h32, 16'h00E0);
    for (int i = 0; i < 9; i++) host.wr(6'h20, 16'h1000 + 16'(i));
    rdchk("stat", 6'h32, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      conv(0, 16'h0000);
      chk("pop", 16'h1000 + 16'(i), o_conv_in_data);
      if (i == 4) begin
        chk("dma_in", 16'h0001, {15'h0000, o_dma_req_cvsd_in});
        chk("fifo_irq", 16'h0001, {15'h0000, o_fifo_irq});
        rdchk("stat", 6'h32, 16'h0081);
        chk("dma_in", 16'h0000, {15'h0000, o_dma_req_cvsd_in});
      end
    end
    conv(0, 16'h0000);
    chk("err_irq", 16'h0001, {15'h0000, o_err_irq});
    rdchk("stat", 6'h32, 16'h00E8);
    chk("err_irq", 16'h0000, {15'h0000, o_err_irq});
    $display("test in_fifo done");
  endtask
  task automatic t_out;
    host.wr(6'h30, 16'h006D);
    for (int i = 0; i < 5; i++) conv(1, 16'h2000 + 16'(i));
    chk("dma_out", 16'h0001, {15'h0000, o_dma_req_cvsd_out});
    chk("fifo_irq", 16'h0001, {15'h0000, o_fifo_irq});
    i_freeze = 1'b1;
    rdchk("stat", 6'h32, 16'h05E2);
    rdchk("stat", 6'h32, 16'h05E0);
    conv(1, 16'hDEAD);
    host.lvl(v);
    chk("lvl", 16'h0005, v);
    i_freeze = 1'b0;
    for (int i = 5; i < 9; i++) conv(1, 16'h2000 + 16'(i));
    chk("err_irq", 16'h0001, {15'h0000, o_err_irq});
    i_freeze = 1'b1;
    rdchk("stat", 6'h32, 16'h07F0);
    i_freeze = 1'b0;
    rdchk("stat", 6'h32, 16'h07F0);
    rdchk("stat", 6'h32, 16'h07E0);
    for (int i = 0; i < 8; i++) rdchk("out", 6'h22, 16'h2000 + 16'(i));
    rdchk("stat", 6'h32, 16'h00E2);
    $display("test out_fifo done");
  endtask
  task automatic t_pcm;
    host.wr(6'h30, 16'hD101);
    host.wr(6'h24, 16'h8000);
    conv(3, 16'h0000);
    chk("pcm_in", 16'hF000, o_conv_pcm_in_data);
    chk("dma_pcm", 16'h0001, {15'h0000, o_dma_req_pcm_in});
    rdchk("stat", 6'h32, 16'h00E4);
    host.wr(6'h30, 16'h4001);
    host.wr(6'h24, 16'h0080);
    conv(3, 16'h0000);
    chk("pcm_mu", 16'h3EBE, o_conv_pcm_in_data);
    host.wr(6'h30, 16'h0801);
    host.wr(6'h24, 16'h00AA);
    conv(3, 16'h0000);
    chk("pcm_a", 16'h7E00, o_conv_pcm_in_data);
    host.wr(6'h30, 16'h1091);
    host.wr(6'h24, 16'h7FFF);
    conv(3, 16'h0000);
    chk("pcm_in", 16'h7FFF, o_conv_pcm_in_data);
    chk("dma_pcm", 16'h0000, {15'h0000, o_dma_req_pcm_in});
    chk("pcm_irq", 16'h0001, {15'h0000, o_pcm_irq});
    i_freeze = 1'b1;
    rdchk("stat", 6'h32, 16'h00E4);
    rdchk("stat", 6'h32, 16'h00E4);
    conv(2, 16'h1234);
    i_freeze = 1'b0;
    rdchk("pcm_out", 6'h26, 16'h0000);
    conv(2, 16'h4321);
    chk("dma_pout", 16'h0001, {15'h0000, o_dma_req_pcm_out});
    rdchk("pcm_out", 6'h26, 16'h4321);
    chk("dma_pout", 16'h0000, {15'h0000, o_dma_req_pcm_out});
    $display("test pcm done");
  endtask
  task automatic t_off;
    host.wr(6'h20, 16'h0055);
    host.wr(6'h30, 16'h0000);
    rdchk("stat", 6'h32, 16'h0000);
    host.wr(6'h30, 16'h0001);
    rdchk("stat", 6'h32, 16'h00E0);
    $display("test disable done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog: fixed-length sequences, so a hang only shows as a runaway run
  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(negedge i_core_clk);
    i_resetn = 1'b1;
    t_regs();
    t_in();
    t_out();
    t_pcm();
    t_off();
    end_sim();
  end
endmodule
